// file: rtl/rtu_master_cfg.svh
// constants for the serial parameter-access master
`ifndef RTU_MASTER_CFG_SVH
`define RTU_MASTER_CFG_SVH
`define CMD_READ 8'h03
`define CMD_WRITE_ONE 8'h06
`define CMD_WRITE_MULTI 8'h10
`define CMD_EXC_FLAG 8'h80
`define AXIS_MIN 8'h01
`define AXIS_MAX 8'hF7
`define MAX_READ_WORDS 8'h7F
`define WRITE32_WORDS 8'h02
`define WRITE32_BYTES 8'h04
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define HDR_BYTES 9'h005
`define ECHO_BYTES 9'h008
`define CLK_KHZ 25000
`define CLK_HZ 25000000
`define BAUD_RATE 57600
`define CHAR_BITS 11
`define GAP_HALF_CHARS 7
`define CHAR_CLKS ((`CLK_HZ * `CHAR_BITS + `BAUD_RATE - 1) / `BAUD_RATE)
`define GAP_CLKS_DFLT ((`GAP_HALF_CHARS * `CHAR_CLKS + 1) / 2)
`define RSP_DELAY_MAX_MS 5000
`define RSP_MARGIN_MS 100
`define TIMEOUT_CLKS_DFLT ((`RSP_DELAY_MAX_MS + `RSP_MARGIN_MS) * `CLK_KHZ)
`endif

// file: rtl/rtu_master_pkg.sv
// types for the serial parameter-access master
package rtu_master_pkg;
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE16 = 2'h1,
    OP_WRITE32 = 2'h2
  } op_e;
  typedef enum logic [2:0] {
    ST_OK = 3'h0,
    ST_FRAME_ERR = 3'h1,
    ST_EXCEPTION = 3'h2,
    ST_TIMEOUT = 3'h3,
    ST_BAD_REQ = 3'h4
  } status_e;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_GAP = 5'h02,
    S_SEND = 5'h04,
    S_WAIT = 5'h08,
    S_RECV = 5'h10
  } state_e;
endpackage

// file: rtl/rtu_param_master.sv
// host-side master that reads and writes drive parameters over a byte link
`include "rtu_master_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module rtu_param_master
  import rtu_master_pkg::*;
#(
  parameter int GAP_CLKS = `GAP_CLKS_DFLT,
  parameter int TIMEOUT_CLKS = `TIMEOUT_CLKS_DFLT
)
(
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CMD_VALID_IN,
  output logic CMD_READY_OUT,
  input wire rtu_master_pkg::op_e CMD_OP_IN,
  input wire logic [7:0] CMD_AXIS_IN,
  input wire logic [7:0] CMD_GROUP_IN,
  input wire logic [7:0] CMD_OFFSET_IN,
  input wire logic [7:0] CMD_COUNT_IN,
  input wire logic [31:0] CMD_WDATA_IN,
  input wire logic WORD_ORDER_SELECT_IN,
  output logic TX_VALID_OUT,
  output logic [7:0] TX_DATA_OUT,
  input wire logic TX_READY_IN,
  input wire logic RX_VALID_IN,
  input wire logic [7:0] RX_DATA_IN,
  output logic RD_VALID_OUT,
  output logic [15:0] RD_WORD_OUT,
  output logic RSP_VALID_OUT,
  output rtu_master_pkg::status_e RSP_STATUS_OUT,
  output logic [7:0] RSP_ERR_CODE_OUT
);
  import rtu_master_pkg::*;

  localparam int BUF_LEN = 11;

  if (GAP_CLKS < 1 || GAP_CLKS > 65535)
  begin : gap_check
    $error("GAP_CLKS out of range");
  end
  if (TIMEOUT_CLKS < 1 || TIMEOUT_CLKS > 134217727)
  begin : timeout_check
    $error("TIMEOUT_CLKS out of range");
  end

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] v;
    v = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      v = v[0] ? ((v >> 1) ^ `CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction

  logic rst_meta_ff, rst_n_ff;
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  state_e state_ff, nxt_state;
  logic [7:0] buf_ff [BUF_LEN];
  logic [7:0] nxt_buf [BUF_LEN];
  logic [3:0] len_ff, nxt_len;
  logic [3:0] idx_ff, nxt_idx;
  logic [15:0] crc_ff, nxt_crc;
  logic [15:0] gap_ff, nxt_gap;
  logic [26:0] timer_ff, nxt_timer;
  logic [8:0] rx_idx_ff, nxt_rx_idx;
  logic is_read_ff, nxt_is_read;
  logic exc_ff, nxt_exc;
  logic err_ff, nxt_err;
  logic [7:0] hi_ff, nxt_hi;
  logic ready_ff, nxt_ready;
  logic tx_valid_ff, nxt_tx_valid;
  logic [7:0] tx_data_ff, nxt_tx_data;
  logic rd_valid_ff, nxt_rd_valid;
  logic [15:0] rd_word_ff, nxt_rd_word;
  logic rsp_valid_ff, nxt_rsp_valid;
  status_e rsp_status_ff, nxt_rsp_status;
  logic [7:0] rsp_err_ff, nxt_rsp_err;

  logic [15:0] crc_step;
  logic [8:0] data_end;
  logic [8:0] exp_len;
  logic gap_done;
  logic [15:0] w_first, w_second;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_buf = buf_ff;
    nxt_len = len_ff;
    nxt_idx = idx_ff;
    nxt_crc = crc_ff;
    nxt_timer = timer_ff;
    nxt_rx_idx = rx_idx_ff;
    nxt_is_read = is_read_ff;
    nxt_exc = exc_ff;
    nxt_err = err_ff;
    nxt_hi = hi_ff;
    nxt_ready = 1'b0;
    nxt_tx_valid = tx_valid_ff;
    nxt_tx_data = tx_data_ff;
    nxt_rd_valid = 1'b0;
    nxt_rd_word = rd_word_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_status = rsp_status_ff;
    nxt_rsp_err = rsp_err_ff;
    // idle time since last byte on the line, either direction
    gap_done = (32'(gap_ff) >= GAP_CLKS);
    nxt_gap = (RX_VALID_IN || (tx_valid_ff && TX_READY_IN)) ? 16'h0000 :
              (gap_done ? gap_ff : gap_ff + 16'h0001);
    crc_step = crc_byte(crc_ff, RX_VALID_IN ? RX_DATA_IN : tx_data_ff);
    data_end = 9'h003 + {buf_ff[5], 1'b0};
    exp_len = exc_ff ? `HDR_BYTES :
              (is_read_ff ? data_end + 9'h002 : `ECHO_BYTES);
    w_first = WORD_ORDER_SELECT_IN ? CMD_WDATA_IN[15:0] :
              CMD_WDATA_IN[31:16];
    w_second = WORD_ORDER_SELECT_IN ? CMD_WDATA_IN[31:16] :
               CMD_WDATA_IN[15:0];
    case (state_ff)
      S_IDLE:
      begin
        nxt_ready = 1'b1;
        if (CMD_VALID_IN && ready_ff)
        begin
          nxt_ready = 1'b0;
          nxt_buf[0] = CMD_AXIS_IN;
          nxt_buf[2] = CMD_GROUP_IN;
          nxt_buf[3] = CMD_OFFSET_IN;
          nxt_is_read = (CMD_OP_IN == OP_READ);
          nxt_crc = `CRC_INIT;
          nxt_idx = 4'h0;
          nxt_state = S_GAP;
          if (CMD_OP_IN == OP_READ)
          begin
            nxt_buf[1] = `CMD_READ;
            nxt_buf[4] = 8'h00;
            nxt_buf[5] = CMD_COUNT_IN;
            nxt_len = 4'h6;
          end
          else if (CMD_OP_IN == OP_WRITE16)
          begin
            nxt_buf[1] = `CMD_WRITE_ONE;
            nxt_buf[4] = CMD_WDATA_IN[15:8];
            nxt_buf[5] = CMD_WDATA_IN[7:0];
            nxt_len = 4'h6;
          end
          else
          begin
            nxt_buf[1] = `CMD_WRITE_MULTI;
            nxt_buf[4] = 8'h00;
            nxt_buf[5] = `WRITE32_WORDS;
            nxt_buf[6] = `WRITE32_BYTES;
            nxt_buf[7] = w_first[15:8];
            nxt_buf[8] = w_first[7:0];
            nxt_buf[9] = w_second[15:8];
            nxt_buf[10] = w_second[7:0];
            nxt_len = 4'hB;
          end
          if (CMD_AXIS_IN < `AXIS_MIN || CMD_AXIS_IN > `AXIS_MAX ||
              CMD_OP_IN > OP_WRITE32 || (CMD_OP_IN == OP_READ &&
              (CMD_COUNT_IN == 8'h00 || CMD_COUNT_IN > `MAX_READ_WORDS)))
          begin
            nxt_state = S_IDLE;
            nxt_rsp_valid = 1'b1;
            nxt_rsp_status = ST_BAD_REQ;
            nxt_rsp_err = 8'h00;
          end
        end
      end
      S_GAP:
      begin
        if (gap_done)
        begin
          nxt_tx_valid = 1'b1;
          nxt_tx_data = buf_ff[0];
          nxt_idx = 4'h1;
          nxt_state = S_SEND;
        end
      end
      S_SEND:
      begin
        if (tx_valid_ff && TX_READY_IN)
        begin
          nxt_idx = idx_ff + 4'h1;
          if (idx_ff < len_ff)
          begin
            nxt_crc = crc_step;
            nxt_tx_data = buf_ff[idx_ff];
          end
          else if (idx_ff == len_ff)
          begin
            nxt_crc = crc_step;
            nxt_tx_data = crc_step[7:0];
          end
          else if (idx_ff == len_ff + 4'h1)
          begin
            nxt_tx_data = crc_ff[15:8];
          end
          else
          begin
            nxt_tx_valid = 1'b0;
            nxt_timer = 27'h0000000;
            nxt_rx_idx = 9'h000;
            nxt_crc = `CRC_INIT;
            nxt_exc = 1'b0;
            nxt_err = 1'b0;
            nxt_state = S_WAIT;
          end
        end
      end
      default:
      begin
        if (state_ff == S_WAIT)
        begin
          nxt_timer = timer_ff + 27'h0000001;
          if (32'(timer_ff) >= TIMEOUT_CLKS - 1)
          begin
            nxt_state = S_IDLE;
            nxt_rsp_valid = 1'b1;
            nxt_rsp_status = ST_TIMEOUT;
          end
        end
        if (RX_VALID_IN && (state_ff == S_WAIT || state_ff == S_RECV))
        begin
          nxt_state = S_RECV;
          nxt_crc = crc_step;
          if (rx_idx_ff != 9'h1FF)
          begin
            nxt_rx_idx = rx_idx_ff + 9'h001;
          end
          if (rx_idx_ff == 9'h000)
          begin
            nxt_err = (RX_DATA_IN != buf_ff[0]);
          end
          else if (rx_idx_ff == 9'h001)
          begin
            if (RX_DATA_IN == (buf_ff[1] | `CMD_EXC_FLAG))
              nxt_exc = 1'b1;
            else if (RX_DATA_IN != buf_ff[1])
              nxt_err = 1'b1;
          end
          else if (rx_idx_ff == 9'h002 && exc_ff)
          begin
            nxt_rsp_err = RX_DATA_IN;
          end
          else if (rx_idx_ff == 9'h002 && is_read_ff)
          begin
            if (RX_DATA_IN != {buf_ff[5][6:0], 1'b0})
              nxt_err = 1'b1;
          end
          else if (is_read_ff && !exc_ff && rx_idx_ff < data_end)
          begin
            if (rx_idx_ff[0])
              nxt_hi = RX_DATA_IN;
            else
            begin
              nxt_rd_valid = 1'b1;
              nxt_rd_word = {hi_ff, RX_DATA_IN};
            end
          end
          else if (!is_read_ff && !exc_ff && rx_idx_ff < 9'h006)
          begin
            if (RX_DATA_IN != buf_ff[rx_idx_ff[2:0]])
              nxt_err = 1'b1;
          end
        end
        else if (state_ff == S_RECV && gap_done)
        begin
          nxt_state = S_IDLE;
          nxt_rsp_valid = 1'b1;
          if (err_ff || crc_ff != 16'h0000 || rx_idx_ff != exp_len)
            nxt_rsp_status = ST_FRAME_ERR;
          else if (exc_ff)
            nxt_rsp_status = ST_EXCEPTION;
          else
            nxt_rsp_status = ST_OK;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      state_ff <= S_IDLE;
      for (int i = 0; i < BUF_LEN; i++)
      begin
        buf_ff[i] <= 8'h00;
      end
      len_ff <= 4'h0;
      idx_ff <= 4'h0;
      crc_ff <= `CRC_INIT;
      gap_ff <= 16'h0000;
      timer_ff <= 27'h0000000;
      rx_idx_ff <= 9'h000;
      is_read_ff <= 1'b0;
      exc_ff <= 1'b0;
      err_ff <= 1'b0;
      hi_ff <= 8'h00;
      ready_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
      rd_word_ff <= 16'h0000;
      rsp_valid_ff <= 1'b0;
      rsp_status_ff <= ST_OK;
      rsp_err_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      buf_ff <= nxt_buf;
      len_ff <= nxt_len;
      idx_ff <= nxt_idx;
      crc_ff <= nxt_crc;
      gap_ff <= nxt_gap;
      timer_ff <= nxt_timer;
      rx_idx_ff <= nxt_rx_idx;
      is_read_ff <= nxt_is_read;
      exc_ff <= nxt_exc;
      err_ff <= nxt_err;
      hi_ff <= nxt_hi;
      ready_ff <= nxt_ready;
      tx_valid_ff <= nxt_tx_valid;
      tx_data_ff <= nxt_tx_data;
      rd_valid_ff <= nxt_rd_valid;
      rd_word_ff <= nxt_rd_word;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_status_ff <= nxt_rsp_status;
      rsp_err_ff <= nxt_rsp_err;
    end
  end

  assign CMD_READY_OUT = ready_ff;
  assign TX_VALID_OUT = tx_valid_ff;
  assign TX_DATA_OUT = tx_data_ff;
  assign RD_VALID_OUT = rd_valid_ff;
  assign RD_WORD_OUT = rd_word_ff;
  assign RSP_VALID_OUT = rsp_valid_ff;
  assign RSP_STATUS_OUT = rsp_status_ff;
  assign RSP_ERR_CODE_OUT = rsp_err_ff;
endmodule
`default_nettype wire

// file: tb/rtu_drive_model.sv
// behavioural drive answering parameter requests on the byte link
`timescale 1ns/100ps
`default_nettype none
module rtu_drive_model
  import rtu_tb_pkg::*;
#(
  parameter logic [7:0] AXIS = 8'h05,
  parameter int DLY = 30
)
(
  input wire logic clk_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out = 1'b0,
  output logic rx_valid_out = 1'b0,
  output logic [7:0] rx_data_out = 8'h00,
  input wire logic [1:0] mode_in
);
  frame_t b, r;
  int n = 0;
  int rl;
  logic [15:0] c;
  task automatic reply();
    repeat (DLY) @(posedge clk_in);
    for (int k = 0; k < 6; k++)
      r[k] = b[k];
    rl = 6;
    if (b[1] == 8'h03)
    begin
      r[2] = 8'(b[5] * 2);
      for (int k = 0; k < b[5]; k++)
        {r[3 + 2 * k], r[4 + 2 * k]} = {b[2], b[3] + 8'(k)} ^ 16'hC35A;
      rl = 3 + 2 * b[5];
    end
    if (mode_in == 2'h1)
    begin
      r[1] = b[1] | 8'h80;
      r[2] = 8'h02;
      rl = 3;
    end
    c = crc16(r, rl) ^ {8'h00, {8{mode_in == 2'h2}}};
    {r[rl + 1], r[rl]} = c;
    for (int k = 0; k < rl + 2; k++)
    begin
      @(posedge clk_in);
      #1 rx_valid_out = 1'b1;
      rx_data_out = r[k];
      @(posedge clk_in);
      #1 rx_valid_out = 1'b0;
      rx_data_out = ~r[k];
    end
  endtask
  // random stalls on the byte sink
  // capture on the falling edge, where the offered byte is settled
  always @(negedge clk_in)
  begin
    if (tx_valid_in && tx_ready_out)
      b[n++] = tx_data_in;
  end
  always @(posedge clk_in)
  begin
    #1 tx_ready_out = 1'($urandom);
  end
  initial forever
  begin
    @(posedge clk_in);
    if (n > 1 && n == (b[1] == 8'h10 ? 13 : 8))
    begin
      if (crc16(b, n) == 16'h0000 && b[0] == AXIS)
        reply();
      n = 0;
    end
  end
endmodule
`default_nettype wire

// file: tb/rtu_param_master_chk.sv
// port assertions for the parameter master
`timescale 1ns/100ps
`default_nettype none
module rtu_param_master_chk
  import rtu_master_pkg::*;
#(
  parameter int GAP_CLKS = 20
)
(
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CMD_VALID_IN,
  input wire logic CMD_READY_OUT,
  input wire rtu_master_pkg::op_e CMD_OP_IN,
  input wire logic [7:0] CMD_AXIS_IN,
  input wire logic TX_VALID_OUT,
  input wire logic [7:0] TX_DATA_OUT,
  input wire logic TX_READY_IN,
  input wire logic RX_VALID_IN,
  input wire logic RD_VALID_OUT,
  input wire logic RSP_VALID_OUT,
  input wire rtu_master_pkg::status_e RSP_STATUS_OUT
);
  logic take, acc, first_ff, nxt_first;
  logic [7:0] axis_ff, nxt_axis;
  int idle_ff, nxt_idle;
  assign take = CMD_VALID_IN && CMD_READY_OUT;
  assign acc = TX_VALID_OUT && TX_READY_IN;
  always_comb
  begin
    nxt_idle = idle_ff < GAP_CLKS ? idle_ff + 1 : idle_ff;
    if (RX_VALID_IN || acc)
      nxt_idle = 0;
    nxt_first = take || (first_ff && !acc);
    nxt_axis = take ? CMD_AXIS_IN : axis_ff;
  end
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      idle_ff <= 0;
      first_ff <= 1'b0;
      axis_ff <= 8'h00;
    end
    else
    begin
      idle_ff <= nxt_idle;
      first_ff <= nxt_first;
      axis_ff <= nxt_axis;
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_gap_before: assert property ($rose(TX_VALID_OUT) |-> idle_ff >= GAP_CLKS - 1)
    else $error("frame began inside idle gap");
  a_gap_after: assert property (RSP_VALID_OUT && RSP_STATUS_OUT != ST_BAD_REQ |-> idle_ff >= GAP_CLKS - 1)
    else $error("reply closed before idle gap");
  a_addr_first: assert property (TX_VALID_OUT && first_ff |-> TX_DATA_OUT == axis_ff)
    else $error("first byte is not the axis");
  a_axis_refused: assert property (take && (CMD_AXIS_IN == 8'h00 || CMD_AXIS_IN > 8'hF7) |-> ##[1:2] RSP_VALID_OUT && RSP_STATUS_OUT == ST_BAD_REQ)
    else $error("bad axis not refused");
  a_op_refused: assert property (take && CMD_OP_IN == 2'h3 |-> ##[1:2] RSP_VALID_OUT && RSP_STATUS_OUT == ST_BAD_REQ)
    else $error("bad command not refused");
  a_no_tx_bad: assert property (take && CMD_AXIS_IN == 8'h00 |=> !TX_VALID_OUT [*4])
    else $error("refused request sent bytes");
  a_tx_hold: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
    else $error("byte changed before accept");
  a_word_low: assert property (RD_VALID_OUT |-> $past(RX_VALID_IN))
    else $error("word without low byte");
  c_word: cover property (RD_VALID_OUT);
  c_tmo: cover property (RSP_VALID_OUT && RSP_STATUS_OUT == ST_TIMEOUT);
  c_exc: cover property (RSP_VALID_OUT && RSP_STATUS_OUT == ST_EXCEPTION);
endmodule
bind rtu_param_master rtu_param_master_chk #(.GAP_CLKS(GAP_CLKS)) chk (
  .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .CMD_VALID_IN(CMD_VALID_IN),
  .CMD_READY_OUT(CMD_READY_OUT), .CMD_OP_IN(CMD_OP_IN),
  .CMD_AXIS_IN(CMD_AXIS_IN), .TX_VALID_OUT(TX_VALID_OUT),
  .TX_DATA_OUT(TX_DATA_OUT), .TX_READY_IN(TX_READY_IN),
  .RX_VALID_IN(RX_VALID_IN), .RD_VALID_OUT(RD_VALID_OUT),
  .RSP_VALID_OUT(RSP_VALID_OUT), .RSP_STATUS_OUT(RSP_STATUS_OUT));
`default_nettype wire

// file: tb/rtu_param_master_tb.sv
// self-checking bench for the parameter master
`timescale 1ns/100ps
`default_nettype none
module rtu_param_master_tb;
  import rtu_master_pkg::*;
  import rtu_tb_pkg::*;
  localparam logic [7:0] AX = 8'h05;
  logic clk = 1'b0, rst_n = 1'b0, cv = 1'b0, wo = 1'b0;
  logic cr, txv, txr, rxv, rdv, rv;
  logic [1:0] op = 2'h0, mode = 2'h0;
  logic [7:0] axis = 8'h00, grp = 8'h00, ofs = 8'h00, cnt = 8'h00;
  logic [7:0] txd, rxd, err;
  logic [31:0] wd = 32'h0;
  logic [15:0] rdw;
  status_e st;
  logic [15:0] q_rd[$];
  logic [7:0] q_tx[$];
  logic [2:0] q_st[$];
  int bad_count = 0, check_count = 0, cyc = 0;
  rtu_param_master #(.GAP_CLKS(20), .TIMEOUT_CLKS(500)) dut (
    .CLK_IN(clk), .RESETN_IN(rst_n), .CMD_VALID_IN(cv),
    .CMD_READY_OUT(cr), .CMD_OP_IN(op_e'(op)), .CMD_AXIS_IN(axis),
    .CMD_GROUP_IN(grp), .CMD_OFFSET_IN(ofs), .CMD_COUNT_IN(cnt),
    .CMD_WDATA_IN(wd), .WORD_ORDER_SELECT_IN(wo), .TX_VALID_OUT(txv),
    .TX_DATA_OUT(txd), .TX_READY_IN(txr), .RX_VALID_IN(rxv),
    .RX_DATA_IN(rxd), .RD_VALID_OUT(rdv), .RD_WORD_OUT(rdw),
    .RSP_VALID_OUT(rv), .RSP_STATUS_OUT(st), .RSP_ERR_CODE_OUT(err));
  rtu_drive_model #(.AXIS(AX)) drv (.clk_in(clk), .tx_valid_in(txv),
    .tx_data_in(txd), .tx_ready_out(txr), .rx_valid_out(rxv),
    .rx_data_out(rxd), .mode_in(mode));
  always #20 clk = ~clk;
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [1:0] o, input logic [7:0] a,
    input logic [7:0] n, input logic w, input logic [1:0] m);
    frame_t f;
    int l;
    logic [15:0] c;
    logic [7:0] g, s;
    logic [31:0] d;
    logic rq;
    g = 8'($urandom);
    s = 8'($urandom);
    d = $urandom;
    rq = a == 8'h00 || a > 8'hF7 || o == 2'h3;
    rq = rq || (o == 2'h0 && (n == 8'h00 || n > 8'h7F));
    f[1] = o == 2'h0 ? 8'h03 : o == 2'h1 ? 8'h06 : 8'h10;
    {f[0], f[2], f[3], f[4], f[5], f[6]} = {a, g, s, 8'h00, n, 8'h00};
    if (o == 2'h1)
      {f[4], f[5]} = d[15:0];
    if (o == 2'h2)
      {f[5], f[6], f[7], f[8], f[9], f[10]} =
        {16'h0204, w ? {d[15:0], d[31:16]} : d};
    l = o == 2'h2 ? 11 : 6;
    c = crc16(f, l);
    {f[l + 1], f[l]} = c;
    for (int k = 0; k < l + 2 && !rq; k++)
      q_tx.push_back(f[k]);
    for (int k = 0; k < n && !rq && o == 2'h0 && a == AX && m == 2'h0; k++)
      q_rd.push_back({g, s + 8'(k)} ^ 16'hC35A);
    q_st.push_back(rq ? ST_BAD_REQ : a != AX ? ST_TIMEOUT : m == 2'h1 ?
      ST_EXCEPTION : m == 2'h2 ? ST_FRAME_ERR : ST_OK);
    @(posedge clk);
    #1 {cv, op, axis, grp, ofs, cnt, wd, wo, mode} = {1'b1, o, a, g, s, n, d, w, m};
    while (cr !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 cv = 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    $display("test op %0d axis %h done", o, a);
  endtask
  // outputs looked at mid-cycle, where they are settled
  always @(negedge clk)
  begin
    if (txv === 1'b1 && txr === 1'b1)
      chk(txd, q_tx.size() ? q_tx.pop_front() : 'x);
    if (rdv === 1'b1)
      chk(rdw, q_rd.size() ? q_rd.pop_front() : 'x);
    if (rv === 1'b1)
      chk(st, q_st.size() ? q_st.pop_front() : 'x);
    if (rv === 1'b1 && st === ST_EXCEPTION)
      chk(err, 8'h02);
    if (++cyc == 30000)
    begin
      bad_count++;
      results();
    end
  end
  initial
  begin
    void'($urandom(45));
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    run(2'h0, AX, 8'h02, 1'b0, 2'h0);
    run(2'h0, AX, 8'h7F, 1'b0, 2'h0);
    run(2'h1, AX, 8'h00, 1'b0, 2'h0);
    run(2'h2, AX, 8'h00, 1'b0, 2'h0);
    run(2'h2, AX, 8'h00, 1'b1, 2'h0);
    run(2'h1, 8'hF7, 8'h00, 1'b0, 2'h0);
    run(2'h1, 8'h00, 8'h00, 1'b0, 2'h0);
    run(2'h0, 8'hF8, 8'h01, 1'b0, 2'h0);
    run(2'h3, AX, 8'h01, 1'b0, 2'h0);
    run(2'h0, AX, 8'h80, 1'b0, 2'h0);
    run(2'h0, AX, 8'h02, 1'b0, 2'h1);
    run(2'h2, AX, 8'h00, 1'b0, 2'h1);
    run(2'h1, AX, 8'h00, 1'b0, 2'h2);
    for (int i = 0; i < 3; i++)
      run(2'($urandom_range(0, 2)), AX, 8'($urandom_range(1, 9)), 1'($urandom), 2'h0);
    results();
  end
endmodule
`default_nettype wire

// file: tb/rtu_tb_pkg.sv
// frame type and check value helper for the bench side
package rtu_tb_pkg;
  typedef logic [7:0] frame_t [0:259];
  function automatic logic [15:0] crc16(input frame_t f, input int l);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < l; i++)
    begin
      c ^= {8'h00, f[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
endpackage
